// ===== hw/chgen_pkg.sv
// How it works
// - cache hint rides in tag of posted writes
// - reset returns hint logic to initial state
// - queue settings apply once hinted traffic drains
// - mode picks cpu or interrupt-controller target
// - legacy byte: enable bit0, target bits 3:1
// - newer byte: full target id, zero disables
// - processing hints set TH, steering, hint bits
// - extended processing-hint format never generated
// - steering table holds eight entries
// - hinted reads carry all byte enables cleared
// - tx write-back uses tx steer, descriptor hint
// - rx buffer writes use rx steer, payload hint
// - rx write-back uses rx steer, descriptor hint
// - tx fetch uses descriptor hint, steering zero
// - rx fetch uses rx steer, descriptor hint
// - tx data reads use tx steer, payload hint
// - descriptor hint resets 00b, payload hint 10b
package chgen_pkg;
    // traffic kinds presented with each request
    typedef enum logic [2:0] {
        CHGEN_TX_WB = 3'h0,
        CHGEN_RX_DATA = 3'h1,
        CHGEN_RX_WB = 3'h2,
        CHGEN_TX_FETCH = 3'h3,
        CHGEN_RX_FETCH = 3'h4,
        CHGEN_TX_READ = 3'h5
    } chgen_traffic_t;
    // hint mode select values
    localparam logic CHGEN_MODE_LEGACY = 1'h0;
    localparam logic CHGEN_MODE_NEWER = 1'h1;
    // legacy hint byte fields
    localparam int CHGEN_LEG_EN_BIT = 0;
    localparam int CHGEN_LEG_TGT_LO = 1;
    localparam int CHGEN_LEG_TGT_HI = 3;
    // processing hint reset values
    localparam logic [1:0] CHGEN_DESCRIPTOR_HINT_FIELD_RST = 2'h0;
    localparam logic [1:0] CHGEN_PAYLOAD_HINT_FIELD_RST = 2'h2;
    // steering table depth and socket field
    localparam int CHGEN_ST_ENTRIES = 8;
    localparam int CHGEN_SOCKET_W = 3;
    // outstanding hinted requests tracked
    localparam int CHGEN_CNT_W = 6;
    // queue control bit positions (8-bit control word)
    localparam int CHGEN_C_TX_WB = 0;
    localparam int CHGEN_C_TX_FETCH = 1;
    localparam int CHGEN_C_TX_READ = 2;
    localparam int CHGEN_C_RX_HDR = 3;
    localparam int CHGEN_C_RX_PAY = 4;
    localparam int CHGEN_C_RX_WB = 5;
    localparam int CHGEN_C_RX_FETCH = 6;
    localparam int CHGEN_C_CACHE = 7;
    localparam int CHGEN_CTRL_W = 8;
endpackage : chgen_pkg

// ===== hw/chgen_shadow.sv
`timescale 1ns/1ps
`default_nettype none
// holds a queue's live control, taking the pending value when drained
module chgen_shadow
    import chgen_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // software side
    input wire logic [CHGEN_CTRL_W-1:0] wr_ctrl,
    input wire logic [7:0] wr_steer,
    input wire logic wr_stb,
    // drain state
    input wire logic drained,
    // live settings
    output logic [CHGEN_CTRL_W-1:0] live_ctrl,
    output logic [7:0] live_steer,
    output logic pending
);
    logic [CHGEN_CTRL_W-1:0] pend_ctrl_r;
    logic [7:0] pend_steer_r;
    logic pend_r;
    logic [CHGEN_CTRL_W-1:0] live_ctrl_r;
    logic [7:0] live_steer_r;
    // apply only when nothing hinted in flight and no write this cycle
    wire apply = pend_r & drained & ~wr_stb;

    // pending write capture; write always accepted
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pend_r <= 1'b0;
            pend_ctrl_r <= '0;
            pend_steer_r <= 8'h00;
        end else if (wr_stb) begin
            pend_r <= 1'b1;
            pend_ctrl_r <= wr_ctrl;
            pend_steer_r <= wr_steer;
        end else if (apply) begin
            pend_r <= 1'b0;
        end
    end

    // live copy updated only once drained
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            live_ctrl_r <= '0;
            live_steer_r <= 8'h00;
        end else if (apply) begin
            live_ctrl_r <= pend_ctrl_r;
            live_steer_r <= pend_steer_r;
        end
    end

    assign live_ctrl = live_ctrl_r;
    assign live_steer = live_steer_r;
    assign pending = pend_r;

    a_no_early_apply: assert property (@(posedge sys_clk) disable iff (reset)
        (~drained) |=> $stable(live_ctrl_r))
        else $error("queue control changed while hinted traffic in flight");
endmodule // chgen_shadow
`default_nettype wire

// ===== hw/chgen_drain.sv
`timescale 1ns/1ps
`default_nettype none
// counts hinted requests issued but not yet completed
module chgen_drain
    import chgen_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // events
    input wire logic issue,
    input wire logic done,
    // state
    output logic drained,
    output logic full
);
    logic [CHGEN_CNT_W-1:0] cnt_r;
    logic [CHGEN_CNT_W-1:0] cnt_nxt;
    // done without outstanding is ignored to avoid wrap
    wire dec = done & (cnt_r != '0);

    assign cnt_nxt = cnt_r + CHGEN_CNT_W'(issue) - CHGEN_CNT_W'(dec);
    assign drained = (cnt_r == '0);
    assign full = (cnt_r == {CHGEN_CNT_W{1'b1}});

    // outstanding counter
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // chgen_drain
`default_nettype wire

// ===== hw/chgen_top.sv
`timescale 1ns/1ps
`default_nettype none
// per-request hint generator: cache hint in tag or processing hints
module chgen_top
    import chgen_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // global settings
    input wire logic cache_hint_global_enable,
    input wire logic cache_hint_mode_select,
    input wire logic [1:0] descriptor_hint_field,
    input wire logic [1:0] payload_hint_field,
    input wire logic [1:0] descriptor_hint_wr_val,
    input wire logic [1:0] payload_hint_wr_val,
    input wire logic hint_fields_wr,
    input wire logic requester_enable,
    // per-queue control writes (one rx, one tx queue)
    input wire logic [CHGEN_CTRL_W-1:0] rx_queue_hint_ctrl,
    input wire logic [7:0] rx_queue_steer_field,
    input wire logic rx_ctrl_wr,
    input wire logic [CHGEN_CTRL_W-1:0] tx_queue_hint_ctrl,
    input wire logic [7:0] tx_queue_steer_field,
    input wire logic tx_ctrl_wr,
    // cache target ids
    input wire logic [2:0] legacy_cpu_target,
    input wire logic [7:0] intc_core_target,
    // request in
    input wire logic req_valid,
    input wire logic [2:0] req_traffic,
    input wire logic req_is_read,
    input wire logic [3:0] req_byte_en,
    output logic req_ready,
    // completion of a hinted request
    input wire logic hint_done,
    // hinted request out
    output logic out_valid,
    output logic out_th,
    output logic [7:0] out_steer_tag,
    output logic [1:0] out_ph,
    output logic [7:0] out_tag_hint,
    output logic [3:0] out_byte_en,
    output logic out_extended,
    // status
    output logic [1:0] descriptor_hint_live,
    output logic [1:0] payload_hint_live,
    output logic rx_update_pending,
    output logic tx_update_pending,
    output logic [3:0] steer_table_size
);
    logic [CHGEN_CTRL_W-1:0] rx_live;
    logic [CHGEN_CTRL_W-1:0] tx_live;
    logic [7:0] rx_steer;
    logic [7:0] tx_steer;
    logic drained;
    logic cnt_full;
    logic [1:0] descriptor_hint_field_r;
    logic [1:0] payload_hint_field_r;
    logic out_valid_r;
    logic out_th_r;
    logic [7:0] out_st_r;
    logic [1:0] out_ph_r;
    logic [7:0] out_tag_r;
    logic [3:0] out_be_r;
    // request classification, declared early for the drain counter
    logic out_th_c; // processing hints go on this request
    logic tag_en_c; // cache hint rides in the tag of this request
    logic hinted_c; // the host owes a completion for this request

    // processing hint fields with documented reset values
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            descriptor_hint_field_r <= CHGEN_DESCRIPTOR_HINT_FIELD_RST;
            payload_hint_field_r <= CHGEN_PAYLOAD_HINT_FIELD_RST;
        end else if (hint_fields_wr) begin
            descriptor_hint_field_r <= descriptor_hint_wr_val;
            payload_hint_field_r <= payload_hint_wr_val;
        end
    end
    // inputs kept for visibility of the written globals
    wire unused_globals = ^{descriptor_hint_field, payload_hint_field};

    chgen_drain u_drain (
        .sys_clk(sys_clk),
        .reset(reset),
        .issue(req_valid & req_ready & hinted_c),
        .done(hint_done),
        .drained(drained),
        .full(cnt_full)
    );

    chgen_shadow u_rx (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_ctrl(rx_queue_hint_ctrl),
        .wr_steer(rx_queue_steer_field),
        .wr_stb(rx_ctrl_wr),
        .drained(drained),
        .live_ctrl(rx_live),
        .live_steer(rx_steer),
        .pending(rx_update_pending)
    );

    chgen_shadow u_tx (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_ctrl(tx_queue_hint_ctrl),
        .wr_steer(tx_queue_steer_field),
        .wr_stb(tx_ctrl_wr),
        .drained(drained),
        .live_ctrl(tx_live),
        .live_steer(tx_steer),
        .pending(tx_update_pending)
    );

    // per traffic type selection of enable, steering and hint
    logic sel_en_c;
    logic [7:0] sel_st_c;
    logic [1:0] sel_ph_c;
    logic sel_rx_c;
    always_comb begin
        sel_en_c = 1'b0;
        sel_st_c = 8'h00;
        sel_ph_c = descriptor_hint_field_r;
        sel_rx_c = 1'b0;
        case (req_traffic)
            CHGEN_TX_WB: begin
                sel_en_c = tx_live[CHGEN_C_TX_WB];
                sel_st_c = tx_steer;
            end
            CHGEN_RX_DATA: begin
                sel_en_c = rx_live[CHGEN_C_RX_HDR] | rx_live[CHGEN_C_RX_PAY];
                sel_st_c = rx_steer;
                sel_ph_c = payload_hint_field_r;
                sel_rx_c = 1'b1;
            end
            CHGEN_RX_WB: begin
                sel_en_c = rx_live[CHGEN_C_RX_WB];
                sel_st_c = rx_steer;
                sel_rx_c = 1'b1;
            end
            CHGEN_TX_FETCH: begin
                sel_en_c = tx_live[CHGEN_C_TX_FETCH];
                sel_st_c = 8'h00;
            end
            CHGEN_RX_FETCH: begin
                sel_en_c = rx_live[CHGEN_C_RX_FETCH];
                sel_st_c = rx_steer;
                sel_rx_c = 1'b1;
            end
            CHGEN_TX_READ: begin
                sel_en_c = tx_live[CHGEN_C_TX_READ];
                sel_st_c = tx_steer;
                sel_ph_c = payload_hint_field_r;
            end
            default: begin
                sel_en_c = 1'b0;
            end
        endcase
    end

    // processing hints need the requester enable from config space
    assign out_th_c = sel_en_c & requester_enable;
    // cache hint only on posted writes, per queue, globally enabled
    wire q_cache_c = sel_rx_c ? rx_live[CHGEN_C_CACHE] : tx_live[CHGEN_C_CACHE];
    assign tag_en_c = cache_hint_global_enable & q_cache_c & ~req_is_read;
    // legacy byte: enable in bit 0, cpu target above, upper nibble zero
    wire [7:0] legacy_byte = {4'h0, legacy_cpu_target, 1'b1};
    // newer byte is the whole core id; zero already means disabled
    wire [7:0] newer_byte = intc_core_target;
    wire [7:0] tag_byte_c = (cache_hint_mode_select == CHGEN_MODE_NEWER) ?
        newer_byte : legacy_byte;
    // an all-zero tag byte is no hint at all, so the host never completes it;
    // counting it would leave the drain counter stuck and block queue updates
    assign hinted_c = out_th_c | (tag_en_c & (tag_byte_c != 8'h00));

    // stall when the outstanding counter would overflow
    assign req_ready = ~cnt_full;

    // output register stage
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_valid_r <= 1'b0;
            out_th_r <= 1'b0;
            out_st_r <= 8'h00;
            out_ph_r <= 2'h0;
            out_tag_r <= 8'h00;
            out_be_r <= 4'h0;
        end else begin
            out_valid_r <= req_valid & req_ready;
            out_th_r <= out_th_c;
            out_st_r <= out_th_c ? sel_st_c : 8'h00;
            out_ph_r <= out_th_c ? sel_ph_c : 2'h0;
            out_tag_r <= tag_en_c ? tag_byte_c : 8'h00;
            out_be_r <= (out_th_c & req_is_read) ? 4'h0 : req_byte_en;
        end
    end

    assign out_valid = out_valid_r;
    assign out_th = out_th_r;
    assign out_steer_tag = out_st_r;
    assign out_ph = out_ph_r;
    assign out_tag_hint = out_tag_r;
    assign out_byte_en = out_be_r;
    assign out_extended = 1'b0;
    assign descriptor_hint_live = descriptor_hint_field_r;
    assign payload_hint_live = payload_hint_field_r;
    assign steer_table_size = 4'(CHGEN_ST_ENTRIES);

    a_fetch_steer_zero: assert property (@(posedge sys_clk) disable iff (reset)
        (req_valid && req_ready && req_traffic == CHGEN_TX_FETCH) |=> out_steer_tag == 8'h00)
        else $error("tx fetch steering not zero");
    a_read_be_clear: assert property (@(posedge sys_clk) disable iff (reset)
        (req_valid && req_ready && req_is_read && out_th_c) |=> out_byte_en == 4'h0)
        else $error("hinted read has byte enables");
    a_no_th_unhinted: assert property (@(posedge sys_clk) disable iff (reset)
        (req_valid && !sel_en_c) |=> !out_th)
        else $error("TH set on unhinted queue");
    a_legacy_enbit: assert property (@(posedge sys_clk) disable iff (reset)
        (tag_en_c && cache_hint_mode_select == CHGEN_MODE_LEGACY) |=>
        out_tag_hint[0] && out_tag_hint[7:4] == 4'h0)
        else $error("legacy hint byte malformed");
    a_read_no_tag: assert property (@(posedge sys_clk) disable iff (reset)
        req_is_read |=> out_tag_hint == 8'h00)
        else $error("cache hint on a read");
    a_reset_ph: assert property (@(posedge sys_clk)
        reset |=> descriptor_hint_field_r == 2'h0 && payload_hint_field_r == 2'h2)
        else $error("hint fields reset wrong");
    a_newer_byte: assert property (@(posedge sys_clk) disable iff (reset)
        (tag_en_c && cache_hint_mode_select == CHGEN_MODE_NEWER) |=>
        out_tag_hint == $past(intc_core_target))
        else $error("newer hint byte wrong");
    a_rx_steer: assert property (@(posedge sys_clk) disable iff (reset)
        (out_th_c && req_traffic == CHGEN_RX_WB) |=> out_steer_tag == $past(rx_steer))
        else $error("rx write-back steering wrong");

    // further checks: per traffic selection, gating and reset state
    // the steering, hint and target checks below sample the stage inputs one edge back with $past

    // extended format is never on the wire
    a_ext_never: assert property (@(posedge sys_clk) disable iff (reset)
        out_extended == 1'b0)
        else $error("extended hint format issued");

    // no requester enable, no TH
    a_th_needs_req: assert property (@(posedge sys_clk) disable iff (reset)
        (!requester_enable) |=> !out_th)
        else $error("TH set without requester enable");

    // tx write-back steering from tx queue
    a_tx_wb_steer: assert property (@(posedge sys_clk) disable iff (reset)
        (out_th_c && req_traffic == CHGEN_TX_WB) |=> out_steer_tag == $past(tx_steer))
        else $error("tx write-back steering wrong");

    // tx write-back hint from descriptor field
    a_tx_wb_ph: assert property (@(posedge sys_clk) disable iff (reset)
        (out_th_c && req_traffic == CHGEN_TX_WB) |=> out_ph == $past(descriptor_hint_field_r))
        else $error("tx write-back hint wrong");

    // rx buffer writes: rx steering, payload hint
    a_rx_data_hint: assert property (@(posedge sys_clk) disable iff (reset)
        (out_th_c && req_traffic == CHGEN_RX_DATA) |=>
        out_ph == $past(payload_hint_field_r) && out_steer_tag == $past(rx_steer))
        else $error("rx buffer write hint wrong");

    // rx fetch steering from rx queue
    a_rx_fetch_st: assert property (@(posedge sys_clk) disable iff (reset)
        (out_th_c && req_traffic == CHGEN_RX_FETCH) |=> out_steer_tag == $past(rx_steer))
        else $error("rx fetch steering wrong");

    // tx data reads: tx steering, payload hint
    a_tx_read_hint: assert property (@(posedge sys_clk) disable iff (reset)
        (out_th_c && req_traffic == CHGEN_TX_READ) |=>
        out_ph == $past(payload_hint_field_r) && out_steer_tag == $past(tx_steer))
        else $error("tx read hint wrong");

    // tx fetch is gated by its own enable bit
    a_tx_fetch_gate: assert property (@(posedge sys_clk) disable iff (reset)
        (req_traffic == CHGEN_TX_FETCH && !tx_live[CHGEN_C_TX_FETCH]) |=> !out_th)
        else $error("tx fetch hinted while disabled");

    // outputs quiet right after reset
    a_reset_outputs: assert property (@(posedge sys_clk)
        reset |=> !out_valid && !out_th && out_tag_hint == 8'h00)
        else $error("outputs not cleared by reset");

    // legacy target bits carry the cpu target
    a_legacy_target: assert property (@(posedge sys_clk) disable iff (reset)
        (tag_en_c && cache_hint_mode_select == CHGEN_MODE_LEGACY) |=>
        out_tag_hint[3:1] == $past(legacy_cpu_target))
        else $error("legacy target bits wrong");

    // no cache hint unless enabled for the queue
    a_unhinted_tag: assert property (@(posedge sys_clk) disable iff (reset)
        (!tag_en_c) |=> out_tag_hint == 8'h00)
        else $error("tag hint on unhinted request");

    // a full counter must hold requests back
    a_ready_full: assert property (@(posedge sys_clk) disable iff (reset)
        cnt_full |-> !req_ready)
        else $error("request taken with counter full");

    // steering table size is fixed
    a_table_size: assert property (@(posedge sys_clk) disable iff (reset)
        steer_table_size == 4'h8)
        else $error("steering table size wrong");
endmodule // chgen_top
`default_nettype wire

// ===== test/chgen_rc_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: root complex taking hinted requests, completing them later
module chgen_rc_model
    import chgen_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // hinted request stream from the block
    input wire logic out_valid,
    input wire logic out_th,
    input wire logic [7:0] out_tag_hint,
    // bench control: hold back completions
    input wire logic stall,
    // completion back to the block
    output logic hint_done
);
    logic [7:0] open_r; // hinted requests not yet completed
    wire hinted = out_valid && (out_th || (out_tag_hint != 8'h00));
    // completes at most every other cycle, so drains are never instant
    wire retire = !stall && (open_r != 8'h00) && !hint_done;
    // count and retire; a stall models a slow host
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            open_r <= 8'h00;
            hint_done <= 1'b0;
        end else begin
            hint_done <= retire;
            open_r <= open_r + {7'h00, hinted} - {7'h00, retire};
        end
    end
endmodule // chgen_rc_model
`default_nettype wire

// ===== test/chgen_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module chgen_top_bench
    import chgen_pkg::*;
;
    logic sys_clk = 1'b0, reset = 1'b1, stall = 1'b0, hint_done;
    logic gen = 1'b0, mode = 1'b0, req_en = 1'b1, phw = 1'b0, rxw = 1'b0, txw = 1'b0;
    logic [1:0] dval = 2'h0, pval = 2'h0;
    logic [7:0] rxc = 8'h00, txc = 8'h00, rxs = 8'h00, txs = 8'h00, intc = 8'h00;
    logic [2:0] cpu = 3'h0, req_traffic = 3'h0;
    logic req_valid = 1'b0, req_is_read = 1'b0, req_ready;
    logic [3:0] req_byte_en = 4'h0, out_byte_en, st_size;
    logic out_valid, out_th, out_ext, rx_pend, tx_pend;
    logic [7:0] out_steer_tag, out_tag_hint;
    logic [1:0] out_ph, d_live, p_live;
    int failures = 0, n_compared = 0, cycles = 0;
    // expected steering and hint per traffic kind, desc hint 1, payload 3
    logic [7:0] exp_st [6] = '{8'h03, 8'h05, 8'h05, 8'h00, 8'h05, 8'h03};
    logic [1:0] exp_ph [6] = '{2'h1, 2'h3, 2'h1, 2'h1, 2'h1, 2'h3};
    logic exp_rd [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    // 50 ns period
    always #25 sys_clk = ~sys_clk;
    chgen_top dut_u (.sys_clk(sys_clk), .reset(reset), .cache_hint_global_enable(gen),
        .cache_hint_mode_select(mode), .descriptor_hint_field(dval),
        .payload_hint_field(pval), .descriptor_hint_wr_val(dval), .payload_hint_wr_val(pval),
        .hint_fields_wr(phw), .requester_enable(req_en), .rx_queue_hint_ctrl(rxc),
        .rx_queue_steer_field(rxs), .rx_ctrl_wr(rxw), .tx_queue_hint_ctrl(txc),
        .tx_queue_steer_field(txs), .tx_ctrl_wr(txw), .legacy_cpu_target(cpu),
        .intc_core_target(intc), .req_valid(req_valid), .req_traffic(req_traffic),
        .req_is_read(req_is_read), .req_byte_en(req_byte_en), .req_ready(req_ready),
        .hint_done(hint_done), .out_valid(out_valid), .out_th(out_th),
        .out_steer_tag(out_steer_tag), .out_ph(out_ph), .out_tag_hint(out_tag_hint),
        .out_byte_en(out_byte_en), .out_extended(out_ext), .descriptor_hint_live(d_live),
        .payload_hint_live(p_live), .rx_update_pending(rx_pend),
        .tx_update_pending(tx_pend), .steer_table_size(st_size));
    chgen_rc_model rc_u (.sys_clk(sys_clk), .reset(reset), .out_valid(out_valid),
        .out_th(out_th), .out_tag_hint(out_tag_hint), .stall(stall), .hint_done(hint_done));
    // value compare, four-state
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request; returns at the negedge where the answer stands
    task automatic send(input logic [2:0] t, input logic rd);
        int n;
        n = 0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_traffic <= t;
        req_is_read <= rd;
        req_byte_en <= 4'hF;
        do begin
            @(negedge sys_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 100);
        if (n >= 100) failures++;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        @(negedge sys_clk);
        chk({7'h00, out_valid}, 8'h01);
    endtask
    // queue control write pulse, no wait for it to apply
    task automatic wq(input logic rx, input logic [7:0] c, input logic [7:0] s);
        @(posedge sys_clk);
        if (rx) begin
            rxc <= c;
            rxs <= s;
            rxw <= 1'b1;
        end else begin
            txc <= c;
            txs <= s;
            txw <= 1'b1;
        end
        @(posedge sys_clk);
        rxw <= 1'b0;
        txw <= 1'b0;
    endtask
    // bounded wait until both queues have applied their writes
    task automatic settle();
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while ((rx_pend !== 1'b0 || tx_pend !== 1'b0) && n < 200);
        chk({6'h00, rx_pend, tx_pend}, 8'h00);
    endtask
    // closing report, the only place the run ends
    task automatic tally_and_finish();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // hang guard: whole run is well under 2000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        chk({6'h00, d_live}, 8'h00);
        chk({6'h00, p_live}, 8'h02);
        chk({4'h0, st_size}, 8'h08);
        chk({7'h00, out_ext}, 8'h00);
        // program hint fields, then queues with socket ids only in low bits
        @(posedge sys_clk);
        dval <= 2'h1;
        pval <= 2'h3;
        phw <= 1'b1;
        @(posedge sys_clk);
        phw <= 1'b0;
        @(negedge sys_clk);
        chk({4'h0, d_live, p_live}, 8'h07);
        wq(1'b1, 8'h78, 8'h05);
        wq(1'b0, 8'h07, 8'h03);
        settle();
        // every traffic kind with processing hints
        for (int t = 0; t < 6; t++) begin
            send(3'(t), exp_rd[t]);
            chk({7'h00, out_th}, 8'h01);
            chk(out_steer_tag, exp_st[t]);
            chk({6'h00, out_ph}, {6'h00, exp_ph[t]});
            chk({7'h00, out_ext}, 8'h00);
            if (exp_rd[t]) chk({4'h0, out_byte_en}, 8'h00);
        end
        // requester enable off: no processing hints, byte enables kept
        @(posedge sys_clk);
        req_en <= 1'b0;
        send(3'h4, 1'b1);
        chk({7'h00, out_th}, 8'h00);
        chk({4'h0, out_byte_en}, 8'h0F);
        @(posedge sys_clk);
        req_en <= 1'b1;
        settle();
        // new setting must wait while a hinted request is outstanding
        @(posedge sys_clk);
        stall <= 1'b1;
        send(3'h4, 1'b1);
        wq(1'b1, 8'h00, 8'h00);
        repeat (3) @(negedge sys_clk);
        chk({7'h00, rx_pend}, 8'h01);
        send(3'h4, 1'b1);
        chk({7'h00, out_th}, 8'h01);
        @(posedge sys_clk);
        stall <= 1'b0;
        settle();
        // no hint enabled anywhere: plain requests
        wq(1'b0, 8'h00, 8'h00);
        settle();
        for (int t = 0; t < 6; t++) begin
            send(3'(t), exp_rd[t]);
            chk({7'h00, out_th}, 8'h00);
            chk(out_tag_hint, 8'h00);
        end
        // cache hint in the tag, both modes, on an rx buffer write
        wq(1'b1, 8'h80, 8'h00);
        settle();
        @(posedge sys_clk);
        gen <= 1'b1;
        cpu <= 3'h5;
        intc <= 8'hA5;
        send(3'h1, 1'b0);
        chk(out_tag_hint, 8'h0B);
        chk({7'h00, out_th}, 8'h00);
        @(posedge sys_clk);
        mode <= 1'b1;
        send(3'h1, 1'b0);
        chk(out_tag_hint, 8'hA5);
        @(posedge sys_clk);
        intc <= 8'h00;
        send(3'h1, 1'b0);
        chk(out_tag_hint, 8'h00);
        settle();
        // second reset in mid-run returns everything to initial state
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(negedge sys_clk);
        chk({4'h0, d_live, p_live}, 8'h02);
        @(posedge sys_clk);
        intc <= 8'hA5;
        send(3'h1, 1'b0);
        chk(out_tag_hint, 8'h00);
        tally_and_finish();
    end
endmodule // chgen_top_bench
`default_nettype wire
